// >>> rtl/sfds_pkg.sv
// Shared constants and carrier types for the serial format, data and status block
package sfds_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] SFDS_CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] SFDS_FMT0_OFFSET   = 8'h04;
	localparam logic [7:0] SFDS_FMT1_OFFSET   = 8'h08;
	localparam logic [7:0] SFDS_DATA_OFFSET   = 8'h0c;
	localparam logic [7:0] SFDS_STATUS_OFFSET = 8'h10;

	// ==========================================================
	// Field positions
	localparam int SFDS_ENABLE_POS    = 0;
	localparam int SFDS_FL_POS        = 24;
	localparam int SFDS_HOLD_POS      = 4;
	localparam int SFDS_PE_POS        = 1;
	localparam int SFDS_PS_POS        = 0;
	localparam int SFDS_BUSY_POS      = 31;
	localparam int SFDS_TX_EMPTY_POS  = 20;
	localparam int SFDS_TX_LEVEL_POS  = 16;
	localparam int SFDS_UNDERRUN_POS  = 10;
	localparam int SFDS_OVERRUN_POS   = 9;
	localparam int SFDS_PAR_ERR_POS   = 8;
	localparam int SFDS_RX_FULL_POS   = 4;
	localparam int SFDS_RX_LEVEL_POS  = 0;

	// ==========================================================
	// Reset values and limits
	localparam logic [5:0] SFDS_FL_RESET = 6'h08;
	localparam logic [5:0] SFDS_FL_MIN   = 6'h08;
	localparam logic [5:0] SFDS_FL_MAX   = 6'h20;
	localparam logic [2:0] SFDS_HOLD_RESET = 3'h0;

	// ==========================================================
	// Timing: hold time in system clock periods for code 000
	localparam int SFDS_HOLD_BASE_CYCLES = 2;
	localparam int SFDS_WORD_W           = 32;
	localparam int SFDS_FIFO_DEPTH       = 8;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [2:0] last_bit_hold_time;
		logic       parity_enable;
		logic       parity_sense;
	} sfds_format_type;

	typedef struct packed {
		logic       frame_busy;
		logic       tx_fifo_empty_flag;
		logic [3:0] tx_fifo_level;
		logic       tx_underrun;
		logic       rx_overrun;
		logic       parity_error;
		logic       rx_fifo_full_flag;
		logic [3:0] rx_fifo_level;
	} sfds_status_type;

endpackage

// >>> rtl/sfds_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ns
module sfds_fifo import sfds_pkg::*; #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst,
	// Filling side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	// Draining side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	// Occupancy
	output logic [$clog2(DEPTH):0]          level
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0]   count;
	} sfds_fifo_state_type;

	sfds_fifo_state_type st;
	sfds_fifo_state_type next_st;
	logic [WIDTH-1:0]    mem [DEPTH];
	logic                push;
	logic                pop;

	assign in_ready  = (st.count != (PW+1)'(DEPTH));
	assign out_valid = (st.count != '0);
	assign out_data  = mem[st.rd_ptr];
	assign level     = st.count;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Storage needs no reset; occupancy guards every read
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[st.wr_ptr] <= in_data;
		end
	end

endmodule

// >>> rtl/sfds_hold_timer.sv
// Last-bit hold timer counting 2 << code system clock periods, 128 for code 111
`timescale 1ns/1ns
module sfds_hold_timer import sfds_pkg::*; (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Control
	input  wire logic       start,
	input  wire logic [2:0] code,
	// Result
	output logic            done
);
	typedef struct packed {
		logic       busy;
		logic [7:0] count;
		logic       done;
	} sfds_timer_state_type;

	sfds_timer_state_type st;
	sfds_timer_state_type next_st;
	logic [7:0]           span;

	// Reserved code 111 is treated as the longest legal hold
	assign span = (code == 3'h7) ? 8'(SFDS_HOLD_BASE_CYCLES << 6)
	                             : 8'(SFDS_HOLD_BASE_CYCLES << code);
	assign done = st.done;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.busy  = 1'b1;
			next_st.count = span - 8'h01;
		end else if (st.busy) begin
			if (st.count == 8'h01) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
			next_st.count = st.count - 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// >>> rtl/sfds_top.sv
// Serial slave with format registers, FIFO data port and status over AHB-Lite
// Notes on behaviour
// RL1: In slave mode the last sent bit holds 2..128 clocks by code; 111 reserved.
// RL2: Parity is added and checked only when enabled; sense 1 odd, 0 even.
// RL3: A word written to the data port is pushed into the transmit FIFO.
// RL4: A read of the data port pops and returns the oldest receive FIFO entry.
// RL5: Software must not write the data port while the transmit FIFO is full.
// RL6: Software must not read the data port while the receive FIFO is empty.
// RL7: Frame length counts the parity bit; legal lengths are 8 to 32 bits.
// RL8: Unused bits of the second format register read zero; writes ignored.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module sfds_top import sfds_pkg::*; #(
	parameter int FIFO_DEPTH = SFDS_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Serial link, slave side
	input  wire logic        serial_clock_in,
	input  wire logic        chip_select_n,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe
);
	// ==========================================================
	// State
	typedef enum logic [2:0] {
		SER_IDLE  = 3'b001,
		SER_SHIFT = 3'b010,
		SER_HOLD  = 3'b100
	} sfds_ser_type;

	typedef struct packed {
		logic            engine_enable;
		logic [5:0]      frame_length;
		sfds_format_type fmt;
		logic            bus_pending;
		logic            bus_write;
		logic [7:0]      bus_addr;
		logic            hreadyout;
		logic [31:0]     hrdata;
		logic            hresp;
		sfds_ser_type    ser;
		logic            sclk_prev;
		logic [5:0]      bit_count;
		logic [31:0]     tx_shift;
		logic [31:0]     rx_shift;
		logic            sdo_oe;
		logic            parity_error;
		logic            rx_overrun;
		logic            tx_underrun;
	} sfds_state_type;

	sfds_state_type   st;
	sfds_state_type   next_st;

	// FIFO and timer hookup
	logic                          tx_push;
	logic                          tx_in_ready;
	logic                          tx_out_valid;
	logic                          tx_pop;
	logic [31:0]                   tx_out_data;
	logic [$clog2(FIFO_DEPTH):0]   tx_level;
	logic                          rx_push;
	logic                          rx_in_ready;
	logic [31:0]                   rx_word;
	logic                          rx_out_valid;
	logic                          rx_pop;
	logic [31:0]                   rx_out_data;
	logic [$clog2(FIFO_DEPTH):0]   rx_level;
	logic                          hold_start;
	logic                          hold_done;
	sfds_status_type               status;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] low_mask(input logic [5:0] n);
		low_mask = (n >= 6'd32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
	endfunction

	// Left-aligns data, parity bit right after it, first bit out at bit 31
	function automatic logic [31:0] build_frame(input logic [31:0] word,
			input logic [5:0] fl, input sfds_format_type fmt);
		logic [5:0]  nd;
		logic [31:0] data;
		logic        par;
		logic [31:0] frame;
		nd    = fl - {5'h0, fmt.parity_enable};
		data  = word & low_mask(nd);
		// RL2 parity generation
		par   = (^data) ^ fmt.parity_sense;
		frame = data << (6'd32 - nd);
		if (fmt.parity_enable) begin
			frame = frame | ({31'h0, par} << (6'd31 - nd));
		end
		build_frame = frame;
	endfunction

	function automatic logic fl_legal(input logic [5:0] fl);
		fl_legal = (fl >= SFDS_FL_MIN) && (fl <= SFDS_FL_MAX);
	endfunction

	// ==========================================================
	// Submodules
	sfds_fifo #(
		.WIDTH (SFDS_WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (tx_push),
		.in_ready  (tx_in_ready),
		.in_data   (hwdata),
		.out_valid (tx_out_valid),
		.out_ready (tx_pop),
		.out_data  (tx_out_data),
		.level     (tx_level)
	);

	sfds_fifo #(
		.WIDTH (SFDS_WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (rx_push),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word),
		.out_valid (rx_out_valid),
		.out_ready (rx_pop),
		.out_data  (rx_out_data),
		.level     (rx_level)
	);

	sfds_hold_timer u_hold (
		.mclk  (mclk),
		.rst   (rst),
		.start (hold_start),
		.code  (st.fmt.last_bit_hold_time),
		.done  (hold_done)
	);

	// ==========================================================
	// Status view
	always_comb begin
		status = '0;
		status.frame_busy         = (st.ser != SER_IDLE);
		status.tx_fifo_empty_flag = (tx_level == '0);
		status.tx_fifo_level      = 4'(tx_level);
		status.tx_underrun        = st.tx_underrun;
		status.rx_overrun         = st.rx_overrun;
		status.parity_error       = st.parity_error;
		status.rx_fifo_full_flag  = !rx_in_ready;
		status.rx_fifo_level      = 4'(rx_level);
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [31:0] rx_next;
		logic [31:0] rx_frame;
		logic [31:0] rd;
		logic        load;
		rx_next  = {st.rx_shift[30:0], serial_data_in};
		rx_frame = rx_next & low_mask(st.frame_length);
		rd       = 32'h0;
		load     = 1'b0;
		next_st    = st;
		tx_push    = 1'b0;
		tx_pop     = 1'b0;
		rx_push    = 1'b0;
		rx_pop     = 1'b0;
		hold_start = 1'b0;
		rx_word    = st.fmt.parity_enable ? (rx_frame >> 1) : rx_frame;
		next_st.sclk_prev = serial_clock_in;

		// Bus: address phase taken, data phase runs one wait state
		if (st.bus_pending) begin
			next_st.bus_pending = 1'b0;
			next_st.hreadyout   = 1'b1;
			if (st.bus_write) begin
				case (st.bus_addr)
					SFDS_CTRL_OFFSET: begin
						next_st.engine_enable = hwdata[SFDS_ENABLE_POS];
					end
					SFDS_FMT0_OFFSET: begin
						// RL7 only 8..32 bit frames are kept
						if (fl_legal(hwdata[SFDS_FL_POS +: 6])) begin
							next_st.frame_length = hwdata[SFDS_FL_POS +: 6];
						end
					end
					SFDS_FMT1_OFFSET: begin
						// RL8 only defined bits stored
						next_st.fmt.last_bit_hold_time = hwdata[SFDS_HOLD_POS +: 3];
						next_st.fmt.parity_enable      = hwdata[SFDS_PE_POS];
						next_st.fmt.parity_sense       = hwdata[SFDS_PS_POS];
					end
					SFDS_DATA_OFFSET: begin
						// RL3 push into transmit FIFO; RL5 full write dropped
						tx_push = 1'b1;
					end
					SFDS_STATUS_OFFSET: begin
						// Write one to clear sticky errors
						if (hwdata[SFDS_PAR_ERR_POS]) next_st.parity_error = 1'b0;
						if (hwdata[SFDS_OVERRUN_POS]) next_st.rx_overrun = 1'b0;
						if (hwdata[SFDS_UNDERRUN_POS]) next_st.tx_underrun = 1'b0;
					end
					default: begin
					end
				endcase
			end else begin
				case (st.bus_addr)
					SFDS_CTRL_OFFSET: rd[SFDS_ENABLE_POS] = st.engine_enable;
					SFDS_FMT0_OFFSET: rd[SFDS_FL_POS +: 6] = st.frame_length;
					SFDS_FMT1_OFFSET: begin
						// RL8 unused bits read zero
						rd[SFDS_HOLD_POS +: 3] = st.fmt.last_bit_hold_time;
						rd[SFDS_PE_POS]        = st.fmt.parity_enable;
						rd[SFDS_PS_POS]        = st.fmt.parity_sense;
					end
					SFDS_DATA_OFFSET: begin
						// RL4 pop oldest entry; RL6 empty read returns zero
						rd     = rx_out_valid ? rx_out_data : 32'h0;
						rx_pop = rx_out_valid;
					end
					SFDS_STATUS_OFFSET: begin
						rd[SFDS_BUSY_POS]              = status.frame_busy;
						rd[SFDS_TX_EMPTY_POS]          = status.tx_fifo_empty_flag;
						rd[SFDS_TX_LEVEL_POS +: 4]     = status.tx_fifo_level;
						rd[SFDS_UNDERRUN_POS]          = status.tx_underrun;
						rd[SFDS_OVERRUN_POS]           = status.rx_overrun;
						rd[SFDS_PAR_ERR_POS]           = status.parity_error;
						rd[SFDS_RX_FULL_POS]           = status.rx_fifo_full_flag;
						rd[SFDS_RX_LEVEL_POS +: 4]     = status.rx_fifo_level;
					end
					default: begin
					end
				endcase
				next_st.hrdata = rd;
			end
		end else if (hsel && htrans[1] && hready) begin
			next_st.bus_pending = 1'b1;
			next_st.bus_write   = hwrite;
			next_st.bus_addr    = {haddr[7:2], 2'b00};
			next_st.hreadyout   = 1'b0;
		end

		// Serial engine: sample on rising edge, shift on falling edge
		case (st.ser)
			SER_IDLE: begin
				next_st.sdo_oe = 1'b0;
				if (st.engine_enable && !chip_select_n) begin
					load = 1'b1;
				end
			end
			SER_SHIFT: begin
				if (serial_clock_in && !st.sclk_prev) begin
					next_st.rx_shift  = rx_next;
					next_st.bit_count = st.bit_count + 6'd1;
					if (st.bit_count + 6'd1 == st.frame_length) begin
						// RL2 parity check on received frame
						if (st.fmt.parity_enable &&
								((^rx_frame) != st.fmt.parity_sense)) begin
							next_st.parity_error = 1'b1;
						end
						// Full receive FIFO drops the word and flags it
						rx_push = 1'b1;
						if (!rx_in_ready) next_st.rx_overrun = 1'b1;
						// RL1 start last-bit hold
						hold_start  = 1'b1;
						next_st.ser = SER_HOLD;
					end
				end else if (!serial_clock_in && st.sclk_prev && st.bit_count != 6'd0) begin
					next_st.tx_shift = {st.tx_shift[30:0], 1'b0};
				end
			end
			SER_HOLD: begin
				// RL1 falling edges ignored until hold time ends
				if (hold_done) begin
					if (st.engine_enable && !chip_select_n) begin
						load = 1'b1;
					end else begin
						next_st.ser    = SER_IDLE;
						next_st.sdo_oe = 1'b0;
					end
				end
			end
			default: begin
				next_st.ser = SER_IDLE;
			end
		endcase

		// Deselect or disable aborts a partial frame
		if ((chip_select_n || !st.engine_enable) && st.ser == SER_SHIFT) begin
			next_st.ser    = SER_IDLE;
			next_st.sdo_oe = 1'b0;
			rx_push        = 1'b0;
			hold_start     = 1'b0;
		end

		if (load) begin
			tx_pop            = tx_out_valid;
			next_st.tx_shift  = build_frame(tx_out_valid ? tx_out_data : 32'h0,
			                                st.frame_length, st.fmt);
			next_st.bit_count = 6'd0;
			next_st.ser       = SER_SHIFT;
			next_st.sdo_oe    = 1'b1;
			if (!tx_out_valid) next_st.tx_underrun = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			st               <= '0;
			st.frame_length  <= SFDS_FL_RESET;
			st.fmt.last_bit_hold_time <= SFDS_HOLD_RESET;
			st.hreadyout     <= 1'b1;
			st.ser           <= SER_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign hreadyout       = st.hreadyout;
	assign hrdata          = st.hrdata;
	assign hresp           = st.hresp;
	assign serial_data_out = st.tx_shift[31];
	assign serial_data_oe  = st.sdo_oe;

endmodule

// >>> verif/sfds_top_chk.sv
// Bus and serial-link assertions for the format, data and status block
`timescale 1ns/1ns
module sfds_top_chk import sfds_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// Serial link
	input wire logic        serial_clock_in,
	input wire logic        chip_select_n,
	input wire logic        serial_data_in,
	input wire logic        serial_data_out,
	input wire logic        serial_data_oe
);
	logic bus_take;
	assign bus_take = hsel & htrans[1] & hready & hreadyout;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Transfer steps
	sequence s_taken;
		bus_take;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_wait_once: assert property (s_taken |=> s_wait)
		else $error("wait state not exactly one cycle");
	a_wait_cause: assert property ($fell(hreadyout) |-> $past(bus_take))
		else $error("wait state without a transfer");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_rdata_stands: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a completion");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> hreadyout && hrdata == 32'h0 && !serial_data_oe && !serial_data_out)
		else $error("outputs not quiet after reset");
	a_oe_needs_cs: assert property ($rose(serial_data_oe) |-> !$past(chip_select_n))
		else $error("link driven while not selected");
	a_oe_drop_cause: assert property ($fell(serial_data_oe) |-> $past(chip_select_n))
		else $error("link released while still selected");
	a_bit_steady: assert property (serial_data_oe && serial_clock_in
		&& $past(serial_clock_in) && $past(serial_clock_in, 2) |-> $stable(serial_data_out))
		else $error("output bit moved while clock high");
endmodule

bind sfds_top sfds_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.serial_clock_in(serial_clock_in), .chip_select_n(chip_select_n),
	.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe));

// >>> verif/sfds_spi_master.sv
// Behavioural serial master that clocks frames into and out of the block
`timescale 1ns/1ns
module sfds_spi_master #(
	parameter int HALF = 4
) (
	// Clock
	input wire logic mclk,
	// Link towards the block
	output logic     serial_clock_in,
	output logic     chip_select_n,
	output logic     serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	initial begin
		serial_clock_in = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// Held counts edges from the last rising clock until the block lets go of the line
	task automatic frame(input int n, input logic [31:0] mosi, output logic [31:0] miso,
		output int held);
		miso = 32'h0;
		held = 0;
		@(posedge mclk);
		chip_select_n <= 1'b0;
		repeat (HALF) @(posedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in <= mosi[i];
			repeat (HALF) @(posedge mclk);
			miso = {miso[30:0], serial_data_oe ? serial_data_out : 1'bx};
			serial_clock_in <= 1'b1;
			if (i > 0) begin
				repeat (HALF) @(posedge mclk);
				serial_clock_in <= 1'b0;
			end
		end
		// Release one edge after the last rising clock: the shortest hold is two cycles,
		// and a select still low when it ends would load and pop another frame
		@(posedge mclk);
		held++;
		// Deselect during the hold; the line is then inverted so stale data never matches
		serial_clock_in <= 1'b0;
		chip_select_n <= 1'b1;
		serial_data_in <= ~mosi[0];
		while (serial_data_oe === 1'b1 && held < 400) begin
			@(posedge mclk);
			held++;
		end
		repeat (HALF) @(posedge mclk);
	endtask
endmodule

// >>> verif/sfds_top_tb.sv
// Self-checking bench for the serial format, data and status block
`timescale 1ns/1ns
module sfds_top_tb import sfds_pkg::*;;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdat;
		logic [31:0] rexp;
	} sfds_row_type;
	localparam sfds_row_type ROWS [0:7] = '{
		'{SFDS_FMT1_OFFSET, 32'hffffffff, 32'h00000073},
		'{SFDS_FMT1_OFFSET, 32'h00000015, 32'h00000011},
		'{SFDS_FMT0_OFFSET, 32'h20000000, 32'h20000000},
		'{SFDS_FMT0_OFFSET, 32'h21000000, 32'h20000000},
		'{SFDS_FMT0_OFFSET, 32'h07000000, 32'h20000000},
		'{SFDS_FMT0_OFFSET, 32'h08000000, 32'h08000000},
		'{8'h14, 32'hffffffff, 32'h00000000},
		'{SFDS_FMT1_OFFSET, 32'h00000000, 32'h00000000}};
	logic        mclk, rst, hsel, hwrite, ps, p;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, rd, miso;
	wire logic   hreadyout, hresp, sck, csn, sdi, sdo, sdoe;
	wire logic [31:0] hrdata;
	int          bad_count, num_checks, held, hold;
	sfds_top #(.FIFO_DEPTH(8)) dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.serial_clock_in(sck), .chip_select_n(csn), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_data_oe(sdoe));
	sfds_spi_master #(.HALF(4)) link (.mclk(mclk), .serial_clock_in(sck),
		.chip_select_n(csn), .serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdoe));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Address phase held until taken, data phase until ready; read data taken there
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		rst = 1'b1;
		bad_count = 0;
		num_checks = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		bus(0, SFDS_FMT1_OFFSET, 0); check(rd, 32'h0);
		bus(0, SFDS_FMT0_OFFSET, 0); check(rd, 32'h08000000);
		bus(0, SFDS_STATUS_OFFSET, 0); check(rd, 32'h00100000);
		bus(0, SFDS_DATA_OFFSET, 0); check(rd, 32'h0);
		foreach (ROWS[i]) begin
			bus(1, ROWS[i].addr, ROWS[i].wdat);
			bus(0, ROWS[i].addr, 0); check(rd, ROWS[i].rexp);
		end
		bus(1, SFDS_CTRL_OFFSET, 32'h1);
		// One word beyond the depth is pushed on purpose and must be dropped
		for (int i = 0; i < 9; i++) bus(1, SFDS_DATA_OFFSET, 32'habcdef81 + i);
		bus(0, SFDS_STATUS_OFFSET, 0); check(rd, 32'h00080000);
		for (int i = 0; i < 9; i++) begin
			link.frame(8, 32'h40 + i, miso, held);
			check(miso, i < 8 ? 32'h81 + i : 32'h0);
		end
		bus(0, SFDS_STATUS_OFFSET, 0); check(rd, 32'h00100618);
		for (int i = 0; i < 8; i++) begin
			bus(0, SFDS_DATA_OFFSET, 0); check(rd, 32'h40 + i);
		end
		bus(0, SFDS_DATA_OFFSET, 0); check(rd, 32'h0);
		bus(1, SFDS_STATUS_OFFSET, 32'h700);
		bus(0, SFDS_STATUS_OFFSET, 0); check(rd, 32'h00100000);
		bus(1, SFDS_FMT0_OFFSET, 32'h09000000);
		for (int s = 0; s < 2; s++) begin
			ps = s[0];
			p = ^8'ha5 ^ ps;
			bus(1, SFDS_FMT1_OFFSET, {30'h0, 1'b1, ps});
			bus(1, SFDS_DATA_OFFSET, 32'h5a);
			link.frame(9, {23'h0, 8'ha5, p}, miso, held);
			check(miso, {23'h0, 8'h5a, ^8'h5a ^ ps});
			bus(0, SFDS_DATA_OFFSET, 0); check(rd, 32'ha5);
			bus(0, SFDS_STATUS_OFFSET, 0); check(rd & 32'h100, 32'h0);
			link.frame(9, {23'h0, 8'ha5, ~p}, miso, held);
			bus(0, SFDS_STATUS_OFFSET, 0); check(rd & 32'h100, 32'h100);
			bus(1, SFDS_STATUS_OFFSET, 32'h700);
		end
		bus(1, SFDS_FMT0_OFFSET, 32'h08000000);
		// Every hold code, the reserved one acting as the longest
		for (int c = 0; c < 8; c++) begin
			hold = (c == 7) ? 128 : 2 << c;
			bus(1, SFDS_FMT1_OFFSET, 32'(c) << 4);
			link.frame(8, 0, miso, held);
			check({31'h0, held >= hold && held <= hold + 2}, 32'h1);
		end
		give_verdict();
	end
endmodule
